/* hdl/ata_cmd_pkg.sv */
// constants, opcodes and carriers for the command processor
package ata_cmd_pkg;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_RD_SEC = 8'h20;
    localparam logic [7:0] OP_WR_SEC = 8'h30;
    localparam logic [7:0] OP_VERIFY0 = 8'h40;
    localparam logic [7:0] OP_VERIFY1 = 8'h41;
    localparam logic [7:0] OP_RD_MULT = 8'hC4;
    localparam logic [7:0] OP_WR_MULT = 8'hC5;
    localparam logic [7:0] OP_SET_MULT = 8'hC6;
    localparam logic [7:0] OP_RD_DMA = 8'hC8;
    localparam logic [7:0] OP_WR_DMA = 8'hCA;
    localparam logic [7:0] OP_STBY_IMM0 = 8'hE0;
    localparam logic [7:0] OP_STBY_IMM1 = 8'h94;
    localparam logic [7:0] OP_IDLE_IMM0 = 8'hE1;
    localparam logic [7:0] OP_IDLE_IMM1 = 8'h95;
    localparam logic [7:0] OP_STBY0 = 8'hE2;
    localparam logic [7:0] OP_STBY1 = 8'h96;
    localparam logic [7:0] OP_IDLE0 = 8'hE3;
    localparam logic [7:0] OP_IDLE1 = 8'h97;
    localparam logic [7:0] OP_RD_BUF = 8'hE4;
    localparam logic [7:0] OP_CHK_PWR0 = 8'hE5;
    localparam logic [7:0] OP_CHK_PWR1 = 8'h98;
    localparam logic [7:0] OP_SLEEP0 = 8'hE6;
    localparam logic [7:0] OP_SLEEP1 = 8'h99;
    localparam logic [7:0] OP_FLUSH = 8'hE7;
    localparam logic [7:0] OP_WR_BUF = 8'hE8;
    localparam logic [7:0] OP_IDENTIFY = 8'hEC;
    localparam logic [7:0] OP_SET_FEAT = 8'hEF;
    localparam logic [7:0] OP_SEC_SETPW = 8'hF1;
    localparam logic [7:0] OP_SEC_UNLOCK = 8'hF2;
    localparam logic [7:0] OP_SEC_EPREP = 8'hF3;
    localparam logic [7:0] OP_SEC_EUNIT = 8'hF4;
    localparam logic [7:0] OP_SEC_FREEZE = 8'hF5;
    localparam logic [7:0] OP_SEC_DISPW = 8'hF6;
    // set features selector that carries a transfer mode
    localparam logic [7:0] FEAT_XFER_MODE = 8'h03;
    localparam logic [7:0] NOP_SUB_ABORT_Q = 8'h00;
    localparam logic [7:0] MULT_RESET = 8'h01;
    localparam logic [7:0] XFER_RESET = 8'h00;
    // sector geometry: 512 bytes as 256 16-bit words
    localparam int WORDS_PER_SEC = 256;
    localparam logic [8:0] SEC_ZERO_MEANS = 9'h100;
    localparam logic [7:0] WORD_LAST = 8'hFF;
    // check power mode answers
    localparam logic [7:0] PWR_CODE_ACTIVE = 8'hFF;
    localparam logic [7:0] PWR_CODE_SLEEP = 8'h00;
    localparam logic [7:0] PWR_CODE_IDLE = 8'h80;
    // ata status and error bits
    localparam int ST_ERR = 0;
    localparam int ST_DRQ = 3;
    localparam int ST_DRDY = 6;
    localparam int ST_BSY = 7;
    localparam logic [7:0] ERR_ABRT = 8'h04;
    localparam logic [7:0] ERR_UNC = 8'h40;
    localparam logic [7:0] ERR_NONE = 8'h00;
    // password control word bit: 1 selects master
    localparam int PW_MASTER_BIT = 0;

    typedef enum logic [1:0] {PWR_ACTIVE, PWR_IDLE, PWR_SLEEP} pwr_mode_t;

    // one host command as delivered by the link layer
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] features;
        logic [7:0] count;
        logic [27:0] lba;
    } ata_cmd_t;

    // completion reported back to the link layer
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] error;
        logic [7:0] count;
    } ata_done_t;
endpackage : ata_cmd_pkg

/* hdl/ata_command_processor.sv */
// command decode and sequencing of a flash storage card
`timescale 1ns/100ps
module ata_command_processor
    import ata_cmd_pkg::*;
#(
    parameter int BLOCKS = 16,
    parameter int BLK_W = 4,
    parameter int ERASE_W = 16,
    parameter logic [15:0] WL_THRESHOLD = 16'h0040
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire ata_cmd_t cmd_in,
    output logic cmd_ready_out,
    // host data words in and out
    input wire logic hwr_valid_in,
    input wire logic [15:0] hwr_data_in,
    output logic hwr_ready_out,
    output logic hrd_valid_out,
    output logic [15:0] hrd_data_out,
    input wire logic hrd_ready_in,
    output logic drq_out,
    output logic bsy_out,
    output logic irq_out,
    output logic done_out,
    output ata_done_t done_info_out,
    output logic queue_abort_out,
    output logic dma_mode_out,
    output logic [7:0] xfer_mode_out,
    output logic auto_pd_out,
    output logic frozen_out,
    // flash side: sector operations
    output logic fl_req_out,
    output logic fl_write_out,
    output logic [27:0] fl_lba_out,
    output logic [BLK_W-1:0] fl_block_out,
    input wire logic fl_ack_in,
    input wire logic fl_fail_in,
    input wire logic fl_ecc_err_in,
    input wire logic [ERASE_W-1:0] erase_cnt_in [BLOCKS],
    input wire logic [BLOCKS-1:0] blk_free_in,
    output logic [BLOCKS-1:0] blk_bad_out,
    output logic static_wl_out,
    input wire logic cache_dirty_in,
    output logic cache_flush_out
);
    typedef enum {S_IDLE, S_HOST_IN, S_HOST_OUT, S_FLASH, S_DONE} state_t;
    typedef enum {K_NONE, K_READ, K_WRITE, K_VERIFY, K_IDENT, K_RDBUF, K_WRBUF, K_PASSWORD, K_FLUSH} kind_t;

    state_t state_r, state_nxt;
    kind_t kind_r;
    ata_cmd_t cmd_r;
    logic [8:0] secs_left_r;
    logic [7:0] word_r;
    logic [7:0] blk_left_r;
    logic [7:0] mult_r;
    logic mult_en_r;
    logic [7:0] xfer_r;
    pwr_mode_t pwr_r;
    logic auto_pd_r;
    logic frozen_r;
    logic prep_armed_r;
    logic [15:0] buf_r [WORDS_PER_SEC];
    logic [15:0] pw_user_r, pw_master_r;
    logic [BLOCKS-1:0] bad_r;
    logic irq_r, done_r;
    ata_done_t info_r;
    logic qabort_r;
    logic [15:0] rd_data_r;
    logic [15:0] bch_par_r;

    // opcode classes
    wire logic [7:0] op = cmd_in.opcode;
    wire logic op_rd = (op == OP_RD_SEC) || (op == OP_RD_DMA) || (op == OP_RD_MULT);
    wire logic op_wr = (op == OP_WR_SEC) || (op == OP_WR_DMA) || (op == OP_WR_MULT);
    wire logic op_mult = (op == OP_RD_MULT) || (op == OP_WR_MULT);
    wire logic op_ver = (op == OP_VERIFY0) || (op == OP_VERIFY1);
    wire logic op_sec = (op == OP_SEC_SETPW) || (op == OP_SEC_UNLOCK) || (op == OP_SEC_DISPW)
        || (op == OP_SEC_EPREP) || (op == OP_SEC_EUNIT);
    wire logic op_sleep = (op == OP_SLEEP0) || (op == OP_SLEEP1) || (op == OP_STBY0) || (op == OP_STBY1)
        || (op == OP_STBY_IMM0) || (op == OP_STBY_IMM1);
    wire logic op_idle = (op == OP_IDLE0) || (op == OP_IDLE1);
    wire logic op_idle_imm = (op == OP_IDLE_IMM0) || (op == OP_IDLE_IMM1);
    wire logic op_chk = (op == OP_CHK_PWR0) || (op == OP_CHK_PWR1);
    wire logic op_known = op_rd || op_wr || op_ver || op_sec || op_sleep || op_idle || op_idle_imm || op_chk
        || (op == OP_FLUSH) || (op == OP_IDENTIFY) || (op == OP_SET_FEAT) || (op == OP_SET_MULT)
        || (op == OP_RD_BUF) || (op == OP_WR_BUF) || (op == OP_SEC_FREEZE);
    // abort: nop, unknown, frozen security, multiple without mode, unit without prepare
    wire logic abort_cmd = (op == OP_NOP) || !op_known
        || (frozen_r && op_sec)
        || (op_mult && !mult_en_r)
        || ((op == OP_SEC_EUNIT) && !prep_armed_r);
    wire logic [8:0] count_secs = (cmd_in.count == 8'h00) ? SEC_ZERO_MEANS : {1'b0, cmd_in.count};
    wire logic take = cmd_valid_in && (state_r == S_IDLE);

    // dynamic wear leveling: least erased good free block
    logic [BLK_W-1:0] pick_idx;
    logic [ERASE_W-1:0] pick_cnt, free_max, data_min;
    always_comb begin
        pick_idx = '0;
        pick_cnt = '1;
        free_max = '0;
        data_min = '1;
        for (int i = 0; i < BLOCKS; i++) begin
            if (blk_free_in[i] && !bad_r[i] && erase_cnt_in[i] < pick_cnt) begin
                pick_cnt = erase_cnt_in[i];
                pick_idx = BLK_W'(i);
            end
            if (blk_free_in[i] && !bad_r[i] && erase_cnt_in[i] > free_max) free_max = erase_cnt_in[i];
            if (!blk_free_in[i] && !bad_r[i] && erase_cnt_in[i] < data_min) data_min = erase_cnt_in[i];
        end
    end
    // static leveling when free blocks wear past data blocks by the margin
    wire logic wl_gap = (free_max > data_min) && ((free_max - data_min) > ERASE_W'(WL_THRESHOLD));

    // 16-bit bch style parity over the sector word stream
    wire logic [15:0] par_next = bch_par_r ^ hwr_data_in ^ {bch_par_r[14:0], bch_par_r[15]};

    wire logic host_in_fire = (state_r == S_HOST_IN) && hwr_valid_in;
    wire logic host_out_fire = (state_r == S_HOST_OUT) && hrd_ready_in;
    wire logic last_word = (word_r == WORD_LAST);
    wire logic multi_blk = (kind_r == K_READ || kind_r == K_WRITE) && (cmd_r.opcode == OP_RD_MULT
        || cmd_r.opcode == OP_WR_MULT);

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: if (take) begin
                if (abort_cmd) state_nxt = S_DONE;
                else if (op_rd || op_ver || (op == OP_FLUSH)) state_nxt = S_FLASH;
                else if (op_wr || op == OP_WR_BUF || op == OP_SEC_SETPW || op == OP_SEC_UNLOCK
                    || op == OP_SEC_DISPW || op == OP_SEC_EUNIT) state_nxt = S_HOST_IN;
                else if (op == OP_IDENTIFY || op == OP_RD_BUF) state_nxt = S_HOST_OUT;
                else state_nxt = S_DONE;
            end
            S_HOST_IN: if (host_in_fire && last_word)
                state_nxt = (kind_r == K_WRITE) ? S_FLASH : S_DONE;
            S_HOST_OUT: if (host_out_fire && last_word)
                state_nxt = (kind_r == K_READ && secs_left_r != 9'h001) ? S_FLASH : S_DONE;
            S_FLASH: if (fl_ack_in) begin
                if (fl_fail_in || fl_ecc_err_in || kind_r == K_FLUSH) state_nxt = S_DONE;
                else if (kind_r == K_READ) state_nxt = S_HOST_OUT;
                else if (secs_left_r == 9'h001) state_nxt = S_DONE;
                else if (kind_r == K_WRITE) state_nxt = S_HOST_IN;
                else state_nxt = S_FLASH;
            end
            S_DONE: state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    // command capture and settings
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cmd_r <= '0;
            kind_r <= K_NONE;
            mult_r <= MULT_RESET;
            mult_en_r <= 1'b0;
            xfer_r <= XFER_RESET;
            pwr_r <= PWR_ACTIVE;
            auto_pd_r <= 1'b0;
            frozen_r <= 1'b0;
            prep_armed_r <= 1'b0;
            qabort_r <= 1'b0;
        end else begin
            qabort_r <= take && (op == OP_NOP) && (cmd_in.features == NOP_SUB_ABORT_Q);
            if (take) begin
                cmd_r <= cmd_in;
                prep_armed_r <= (op == OP_SEC_EPREP) && !frozen_r;
                if (abort_cmd) kind_r <= K_NONE;
                else begin
                    kind_r <= (op_rd) ? K_READ : (op_wr) ? K_WRITE : op_ver ? K_VERIFY
                        : (op == OP_IDENTIFY) ? K_IDENT : (op == OP_RD_BUF) ? K_RDBUF
                        : (op == OP_WR_BUF) ? K_WRBUF : (op == OP_FLUSH) ? K_FLUSH
                        : (op == OP_SEC_SETPW) ? K_PASSWORD : K_NONE;
                    if (op == OP_SET_FEAT && cmd_in.features == FEAT_XFER_MODE) xfer_r <= cmd_in.count;
                    if (op == OP_SET_MULT) begin
                        mult_r <= cmd_in.count;
                        mult_en_r <= (cmd_in.count != 8'h00);
                    end
                    if (op == OP_SEC_FREEZE) frozen_r <= 1'b1;
                    if (op_sleep) pwr_r <= PWR_SLEEP;
                    if (op_idle || op_idle_imm) pwr_r <= PWR_IDLE;
                    if (op_idle) auto_pd_r <= (cmd_in.count != 8'h00);
                    if (op_rd || op_wr || op_ver) pwr_r <= PWR_ACTIVE;
                end
            end
        end
    end

    // sector, word and block counters
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_r <= S_IDLE;
            secs_left_r <= '0;
            word_r <= '0;
            blk_left_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (take) begin
                secs_left_r <= (op_rd || op_wr || op_ver) ? count_secs : 9'h001;
                blk_left_r <= mult_r;
                word_r <= '0;
            end else if (host_in_fire || host_out_fire) begin
                word_r <= word_r + 8'h01;
                if (last_word && (kind_r == K_READ) && secs_left_r != 9'h001) secs_left_r <= secs_left_r - 9'h001;
                if (last_word) blk_left_r <= (blk_left_r == 8'h01) ? mult_r : blk_left_r - 8'h01;
            end else if (state_r == S_FLASH && fl_ack_in && kind_r != K_READ && secs_left_r != 9'h001)
                secs_left_r <= secs_left_r - 9'h001;
        end
    end

    // sector buffer, passwords and parity
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pw_user_r <= '0;
            pw_master_r <= '0;
            bch_par_r <= '0;
        end else begin
            if (take) bch_par_r <= '0;
            else if (host_in_fire) bch_par_r <= par_next;
            // password word 1 lands once the control word is known
            if (host_in_fire && kind_r == K_PASSWORD && word_r == 8'h01) begin
                if (buf_r[0][PW_MASTER_BIT]) pw_master_r <= hwr_data_in;
                else pw_user_r <= hwr_data_in;
            end
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (host_in_fire) buf_r[word_r] <= hwr_data_in;
    end

    // read data register; identify block is zero apart from the buffer path
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) rd_data_r <= '0;
        else if (state_nxt == S_HOST_OUT) rd_data_r <= (kind_r == K_IDENT) ? 16'h0000
            : buf_r[(host_out_fire) ? word_r + 8'h01 : word_r];
    end

    // completion, interrupt and bad block marking
    wire logic fl_bad = (state_r == S_FLASH) && fl_ack_in && (fl_fail_in || fl_ecc_err_in);
    wire logic blk_irq = (host_in_fire || host_out_fire) && last_word && multi_blk && blk_left_r == 8'h01;
    wire logic sec_irq = (host_in_fire || host_out_fire) && last_word && !multi_blk && kind_r == K_READ;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            bad_r <= '0;
            irq_r <= 1'b0;
            done_r <= 1'b0;
            info_r <= '0;
        end else begin
            if (fl_bad) bad_r[fl_block_out] <= 1'b1;
            irq_r <= (state_nxt == S_DONE && state_r != S_DONE) || blk_irq || sec_irq;
            done_r <= (state_nxt == S_DONE && state_r != S_DONE);
            if (state_nxt == S_DONE && state_r != S_DONE) begin
                info_r.status <= 8'h00;
                info_r.status[ST_DRDY] <= 1'b1;
                info_r.status[ST_ERR] <= (state_r == S_IDLE && abort_cmd) || fl_bad;
                info_r.error <= (state_r == S_IDLE && abort_cmd) ? ERR_ABRT : fl_bad ? ERR_UNC : ERR_NONE;
                info_r.count <= (pwr_r == PWR_SLEEP) ? PWR_CODE_SLEEP
                    : (pwr_r == PWR_IDLE) ? PWR_CODE_IDLE : PWR_CODE_ACTIVE;
            end
        end
    end

    // outputs
    assign cmd_ready_out = (state_r == S_IDLE);
    assign hwr_ready_out = (state_r == S_HOST_IN);
    assign hrd_valid_out = (state_r == S_HOST_OUT);
    assign hrd_data_out = rd_data_r;
    assign drq_out = (state_r == S_HOST_IN) || (state_r == S_HOST_OUT);
    assign bsy_out = (state_r == S_FLASH) || (state_r == S_DONE);
    assign irq_out = irq_r;
    assign done_out = done_r;
    assign done_info_out = info_r;
    assign queue_abort_out = qabort_r;
    assign dma_mode_out = (cmd_r.opcode == OP_RD_DMA) || (cmd_r.opcode == OP_WR_DMA);
    assign xfer_mode_out = xfer_r;
    assign auto_pd_out = auto_pd_r;
    assign frozen_out = frozen_r;
    assign fl_req_out = (state_r == S_FLASH);
    assign fl_write_out = (kind_r == K_WRITE) || (kind_r == K_FLUSH);
    assign fl_lba_out = cmd_r.lba + 28'(count_secs_left());
    assign fl_block_out = pick_idx;
    assign blk_bad_out = bad_r;
    assign static_wl_out = wl_gap;
    assign cache_flush_out = (state_r == S_FLASH) && (kind_r == K_FLUSH) && cache_dirty_in;

    function automatic logic [8:0] count_secs_left();
        count_secs_left = ((cmd_r.count == 8'h00) ? SEC_ZERO_MEANS : {1'b0, cmd_r.count}) - secs_left_r;
    endfunction : count_secs_left

    // checks
    a_verify_no_drq: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (kind_r == K_VERIFY) |-> !drq_out) else $error("drq during verify");
    a_flush_busy: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_r == S_FLASH && kind_r == K_FLUSH && !fl_ack_in) |=> bsy_out) else $error("flush not busy");
    a_unknown_abort: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (take && !op_known) |=> (done_out && done_info_out.error == ERR_ABRT))
        else $error("unknown opcode not aborted");
    a_frozen_abort: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (take && frozen_r && op_sec) |=> done_info_out.status[ST_ERR]) else $error("frozen not aborted");
    a_frozen_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        frozen_r |=> frozen_r) else $error("frozen dropped");
    a_mode_adopt: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (take && op == OP_SET_FEAT && cmd_in.features == FEAT_XFER_MODE) |=> (xfer_mode_out == $past(cmd_in.count)))
        else $error("mode not adopted");
    a_bad_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fl_bad |=> blk_bad_out[$past(fl_block_out)]) else $error("bad block not marked");
    a_sleep_enter: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (take && op_sleep && !abort_cmd) |=> (pwr_r == PWR_SLEEP && irq_out)) else $error("sleep sequence");
endmodule : ata_command_processor

/* sim/flash_model.sv */
// flash array stand-in that answers sector operations
`timescale 1ns/100ps
module flash_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic [3:0] dly_in,
    input wire logic fail_en_in,
    input wire logic ecc_en_in,
    output logic ack_out,
    output logic fail_out,
    output logic ecc_out
);
    logic [3:0] cnt_r;
    // ack after a chosen delay; qualifiers toggle off the ack so nothing leans on them
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        fail_out <= rst_in ? 1'b0 : ~fail_out;
        ecc_out <= rst_in ? 1'b0 : ~ecc_out;
        if (rst_in || !req_in) begin
            cnt_r <= 4'h0;
        end else if (cnt_r >= dly_in) begin
            ack_out <= 1'b1;
            fail_out <= fail_en_in;
            ecc_out <= ecc_en_in;
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule : flash_model

/* sim/ata_command_processor_tb.sv */
// self-checking bench for the command processor
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module ata_command_processor_tb import ata_cmd_pkg::*; ;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_valid_in = 1'b0, hwr_valid_in = 1'b0, hrd_ready_in = 1'b0, cache_dirty_in = 1'b0;
    logic fail_en = 1'b0, ecc_en = 1'b0, want_w = 1'b0, hs_w = 1'b0, drq_seen, qa_seen;
    logic cmd_ready_out, hwr_ready_out, hrd_valid_out, drq_out, bsy_out, irq_out, done_out, queue_abort_out;
    logic dma_mode_out, auto_pd_out, frozen_out, fl_req, fl_write, fl_ack, fl_fail, fl_ecc, static_wl_out;
    ata_cmd_t cmd_in = '0;
    ata_done_t info, done_info_out;
    logic [15:0] hwr_data_in = 16'h0000, blk_free_in = 16'h0003, bad = 16'h0000, hrd_data_out, blk_bad_out;
    logic [15:0] ec [16];
    logic [3:0] dly = 4'h2, blk_seen, fl_block, b;
    logic [7:0] mode, xfer_mode_out;
    logic [27:0] fl_lba;
    integer seed = 32'h94f7;
    int fail_count = 0, checks = 0, rd_w, wr_w, gap, irq_n, n;
    // power commands, their counts and the mode code they leave behind
    logic [7:0] pop [6] = '{OP_IDLE0, OP_IDLE1, OP_SLEEP0, OP_STBY_IMM1, OP_IDLE_IMM0, OP_STBY0};
    logic [7:0] pct [6] = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] pex [6] = '{PWR_CODE_IDLE, PWR_CODE_IDLE, PWR_CODE_SLEEP, PWR_CODE_SLEEP, PWR_CODE_IDLE,
        PWR_CODE_SLEEP};
    // data commands, counts, direction and word totals
    logic [7:0] dop [6] = '{OP_IDENTIFY, OP_RD_BUF, OP_RD_DMA, OP_RD_MULT, OP_WR_BUF, OP_WR_MULT};
    logic [7:0] dct [6] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h02};
    int dwd [6] = '{256, 256, 256, 512, 256, 512};

    always #50 clk_sys_in = ~clk_sys_in;

    ata_command_processor dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
        .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .hwr_valid_in(hwr_valid_in), .hwr_data_in(hwr_data_in),
        .hwr_ready_out(hwr_ready_out), .hrd_valid_out(hrd_valid_out), .hrd_data_out(hrd_data_out),
        .hrd_ready_in(hrd_ready_in), .drq_out(drq_out), .bsy_out(bsy_out), .irq_out(irq_out),
        .done_out(done_out), .done_info_out(done_info_out), .queue_abort_out(queue_abort_out),
        .dma_mode_out(dma_mode_out), .xfer_mode_out(xfer_mode_out), .auto_pd_out(auto_pd_out),
        .frozen_out(frozen_out), .fl_req_out(fl_req), .fl_write_out(fl_write), .fl_lba_out(fl_lba),
        .fl_block_out(fl_block), .fl_ack_in(fl_ack), .fl_fail_in(fl_fail), .fl_ecc_err_in(fl_ecc),
        .erase_cnt_in(ec), .blk_free_in(blk_free_in), .blk_bad_out(blk_bad_out),
        .static_wl_out(static_wl_out), .cache_dirty_in(cache_dirty_in), .cache_flush_out());

    flash_model fm (.clk_in(clk_sys_in), .rst_in(rst_in), .req_in(fl_req), .dly_in(dly),
        .fail_en_in(fail_en), .ecc_en_in(ecc_en), .ack_out(fl_ack), .fail_out(fl_fail), .ecc_out(fl_ecc));

    // handshake and pulse bookkeeping at the sampling edge
    always @(posedge clk_sys_in) begin
        hs_w <= hwr_valid_in && hwr_ready_out;
        if (hrd_valid_out && hrd_ready_in) rd_w++;
        if (hwr_valid_in && hwr_ready_out) wr_w++;
        if (drq_out) drq_seen = 1'b1;
        if (irq_out) irq_n++;
        if (queue_abort_out) qa_seen = 1'b1;
        if (fl_req && fl_write) blk_seen = fl_block;
    end

    // least-erased free good block; ties cannot occur, low nibble is the index
    function automatic logic [3:0] least(input logic [15:0] fr, input logic [15:0] bd);
        int k;
        k = 0;
        for (int i = 15; i >= 0; i--) if (fr[i] && !bd[i] && (!fr[k] || bd[k] || ec[i] < ec[k])) k = i;
        return 4'(k);
    endfunction : least

    function automatic logic swl(input logic [15:0] fr);
        int fmax, dmin;
        fmax = 0;
        dmin = 32'h7FFFFFFF;
        for (int i = 0; i < 16; i++) begin
            if (fr[i] && ec[i] > fmax) fmax = ec[i];
            if (!fr[i] && ec[i] < dmin) dmin = ec[i];
        end
        return (fmax - dmin) > int'(16'h0040);
    endfunction : swl

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // offer one command, serve its words with random stalls, wait for completion
    task automatic run(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] ct, input logic wr);
        @(negedge clk_sys_in);
        cmd_in = '{op, ft, ct, 28'($random(seed))};
        cmd_valid_in = 1'b1;
        want_w = wr;
        for (n = 0; n < 50 && cmd_ready_out !== 1'b1; n++) @(negedge clk_sys_in);
        if (n >= 50) begin
            fail_count++;
            final_report();
        end
        @(negedge clk_sys_in);
        cmd_valid_in = 1'b0;
        {rd_w, wr_w, gap, irq_n, drq_seen, qa_seen} = '0;
        for (n = 0; n < 4000 && done_out !== 1'b1; n++) begin
            if (bsy_out !== 1'b1) gap++;
            hrd_ready_in = 1'($random(seed));
            if (!hwr_valid_in || hs_w) begin
                hwr_valid_in = want_w & 1'($random(seed));
                hwr_data_in = 16'($random(seed));
            end
            @(negedge clk_sys_in);
        end
        // let the edge that samples the done and irq pulses pass before counting
        @(negedge clk_sys_in);
        info = done_info_out;
        hwr_valid_in = 1'b0;
        if (n >= 4000) begin
            fail_count++;
            final_report();
        end
    endtask : run

    // main sequence: settings, aborts, power, media, security
    initial begin
        for (int i = 0; i < 16; i++) ec[i] = {4'h0, 8'($random(seed)), 4'(i)};
        repeat (2) @(negedge clk_sys_in);
        rst_in = 1'b0;
        `CHK("frozen after reset", 1'b0, frozen_out)
        run(OP_CHK_PWR0, 8'h00, 8'h00, 1'b0);
        `CHK("power code", PWR_CODE_ACTIVE, info.count)
        mode = 8'($random(seed));
        run(OP_SET_FEAT, FEAT_XFER_MODE, mode, 1'b0);
        `CHK("xfer mode", mode, xfer_mode_out)
        run(OP_SET_FEAT, 8'h02, ~mode, 1'b0);
        `CHK("xfer mode kept", mode, xfer_mode_out)
        run(OP_NOP, NOP_SUB_ABORT_Q, 8'h00, 1'b0);
        `CHK("queue abort", 1'b1, qa_seen)
        `CHK("nop error", ERR_ABRT, info.error)
        run(OP_NOP, 8'($random(seed)) | 8'h01, 8'h00, 1'b0);
        `CHK("queue kept", 1'b0, qa_seen)
        `CHK("nop status", 1'b1, info.status[ST_ERR])
        run(8'h7A, 8'h00, 8'h00, 1'b0);
        `CHK("unknown error", ERR_ABRT, info.error)
        `CHK("unknown keeps mode", mode, xfer_mode_out)
        run(OP_SEC_EUNIT, 8'h00, 8'h00, 1'b1);
        `CHK("erase unit alone", ERR_ABRT, info.error)
        for (int i = 0; i < 6; i++) begin
            run(pop[i], 8'h00, pct[i], 1'b0);
            `CHK("power busy gap", 0, gap)
            `CHK("power irq", 1'b1, irq_n > 0)
            if (i < 2) `CHK("auto powerdown", pct[i] != 8'h00, auto_pd_out)
            run(i[0] ? OP_CHK_PWR1 : OP_CHK_PWR0, 8'h00, 8'h00, 1'b0);
            `CHK("power code", pex[i], info.count)
        end
        dly = 4'h2 + 4'($random(seed) & 7);
        run(OP_RD_SEC, 8'h00, 8'h02, 1'b0);
        `CHK("read words", 512, rd_w)
        run(OP_VERIFY1, 8'h00, 8'h01, 1'b0);
        `CHK("verify drq", 1'b0, drq_seen)
        `CHK("verify words", 0, rd_w)
        run(OP_SET_MULT, 8'h00, 8'h02, 1'b0);
        for (int i = 0; i < 6; i++) begin
            run(dop[i], 8'h00, dct[i], i > 3);
            `CHK("data words", dwd[i], rd_w + wr_w)
            `CHK("dma flag", dop[i] == OP_RD_DMA, dma_mode_out)
            if (i > 2) `CHK("block irq", (dop[i] == OP_WR_MULT) ? 2 : 1, irq_n)
        end
        blk_free_in = 16'($random(seed)) | 16'h0003;
        run(OP_WR_SEC, 8'h00, 8'h01, 1'b1);
        `CHK("write words", 256, wr_w)
        `CHK("write block", least(blk_free_in, bad), blk_seen)
        `CHK("static leveling", swl(blk_free_in), static_wl_out)
        b = least(blk_free_in, bad);
        fail_en = 1'b1;
        run(OP_WR_SEC, 8'h00, 8'h01, 1'b1);
        fail_en = 1'b0;
        bad[b] = 1'b1;
        `CHK("bad map", bad, blk_bad_out)
        run(OP_WR_SEC, 8'h00, 8'h01, 1'b1);
        `CHK("block after fail", least(blk_free_in, bad), blk_seen)
        cache_dirty_in = 1'b1;
        run(OP_FLUSH, 8'h00, 8'h00, 1'b0);
        cache_dirty_in = 1'b0;
        `CHK("flush busy gap", 0, gap)
        run(OP_SEC_FREEZE, 8'h00, 8'h00, 1'b0);
        `CHK("frozen", 1'b1, frozen_out)
        run(OP_SEC_SETPW, 8'h00, 8'h00, 1'b1);
        `CHK("frozen set password", ERR_ABRT, info.error)
        rst_in = 1'b1;
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        `CHK("frozen cleared", 1'b0, frozen_out)
        final_report();
    end
endmodule : ata_command_processor_tb
